// ### core/lbus_watchpoint_defines.vh
// Offsets, field positions, encodings and reset values of the L-bus debug logic
`ifndef LBUS_WATCHPOINT_DEFINES_VH
`define LBUS_WATCHPOINT_DEFINES_VH
`define SPR_LBUS_COMPARATOR_CONFIG 10'h09C
`define SPR_LBUS_WATCHPOINT_CONFIG 10'h09D
`define LBUS_CMP_CFG_RESET         32'h00000000
`define LBUS_WP_CFG_RESET          32'h00000000
// Writable bits of each register; reserved bits read zero
`define LBUS_CMP_CFG_WMASK         32'hFFFFFFFC
`define LBUS_WP_CFG_WMASK          32'hFFFFF803
// Comparator configuration fields (bit 0 of the manual is bit 31 here)
`define CT_ADDR0      31:29
`define CT_ADDR1      28:26
`define CT_DATA0      25:23
`define CT_DATA1      22:20
`define RW_ADDR0      19:18
`define RW_ADDR1      17:16
`define SZ_DATA0      15:14
`define SZ_DATA1      13:12
`define SG_DATA0      11
`define SG_DATA1      10
`define BM_DATA0      9:6
`define BM_DATA1      5:2
// Watchpoint configuration fields
`define WP0_EN        31
`define WP0_IA        30:29
`define WP0_IA_CARE   28
`define WP0_LA        27:26
`define WP0_LA_CARE   25
`define WP0_LD        24:23
`define WP0_LD_CARE   22
`define WP1_EN        21
`define WP1_IA        20:19
`define WP1_IA_CARE   18
`define WP1_LA        17:16
`define WP1_LA_CARE   15
`define WP1_LD        14:13
`define WP1_LD_CARE   12
`define BRK_NONMASK   11
`define DEV_TRAP0     3
`define DEV_TRAP1     2
`define SW_TRAP0      1
`define SW_TRAP1      0
// Compare type codes
`define CT_EQ         3'h4
`define CT_LT         3'h5
`define CT_GT         3'h6
`define CT_NE         3'h7
// Read/write qualifier codes
`define RW_WRITE      2'h3
`define RW_READ       2'h2
// Compare size codes
`define SZ_WORD       2'h1
`define SZ_HALF       2'h2
`define SZ_BYTE       2'h3
// Show-cycle codes
`define SC_ALL        2'h0
`define SC_FLOW       2'h1
`define SC_INDIRECT   2'h2
`define SC_NONE       2'h3
// Event combine codes
`define SEL_FIRST     2'h0
`define SEL_SECOND    2'h1
`define SEL_AND       2'h2
`define SEL_OR        2'h3
`endif

// ### core/lbus_watchpoint_compare_ctrl.v
// Show-cycle control and L-bus watchpoint comparators with their registers
`include "lbus_watchpoint_defines.vh"

module lbus_watchpoint_compare_ctrl (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [9:0]  spr_addr,
  input  wire        spr_wr,
  input  wire        spr_rd,
  input  wire [31:0] spr_wdata,
  output reg  [31:0] spr_rdata_r,
  input  wire [2:0]  showcycle_serialize_field,
  input  wire        fetch_valid,
  input  wire        flow_change,
  input  wire        flow_indirect,
  output reg         serialize_core_r,
  output reg         fetch_showcycle_r,
  input  wire        lbus_valid,
  input  wire        lbus_write,
  input  wire [31:0] lbus_addr,
  input  wire [31:0] lbus_data,
  input  wire [31:0] ref_addr0,
  input  wire [31:0] ref_addr1,
  input  wire [31:0] ref_data0,
  input  wire [31:0] ref_data1,
  input  wire [3:0]  ibus_wp_event,
  input  wire [1:0]  dev_trap_enable,
  input  wire        recoverable_irq_status,
  output reg  [3:0]  cmp_match_r,
  output reg  [1:0]  lbus_wp_r,
  output reg  [1:0]  sw_break_r,
  output reg  [1:0]  dev_break_r
);

  reg  [31:0] lbus_comparator_config_r;
  reg  [31:0] lbus_watchpoint_config_r;
  reg  [31:0] rdata_nxt;
  reg  [3:0]  match_nxt;
  reg  [1:0]  wp_nxt;
  reg         recog;
  reg         sc_nxt;

  wire [1:0]  fetch_showcycle_code;
  wire        serialize_disable;
  wire        breakpoint_nonmask;

  assign serialize_disable    = showcycle_serialize_field[2];
  assign fetch_showcycle_code = showcycle_serialize_field[1:0];
  assign breakpoint_nonmask   = lbus_watchpoint_config_r[`BRK_NONMASK];

  // Signed magnitude compare of two 33-bit operands, zero- or sign-extended by the caller
  function cmp_fn;
    input [2:0]  ctype;
    input [32:0] a;
    input [32:0] b;
    reg signed [32:0] sa;
    reg signed [32:0] sb;
    begin
      sa = a;
      sb = b;
      case (ctype)
        `CT_EQ:  cmp_fn = (sa == sb);
        `CT_LT:  cmp_fn = (sa < sb);
        `CT_GT:  cmp_fn = (sa > sb);
        `CT_NE:  cmp_fn = (sa != sb);
        default: cmp_fn = 1'b0;
      endcase
    end
  endfunction

  // Address operand: always unsigned
  function [32:0] addr_ext;
    input [31:0] a;
    begin
      addr_ext = {1'b0, a};
    end
  endfunction

  // Data operand: byte lanes masked, then sized and extended
  function [32:0] data_ext;
    input [31:0] d;
    input [3:0]  mask;
    input [1:0]  size;
    input        sgn;
    reg   [31:0] m;
    begin
      // Mask bit 3 covers the first byte lane, bits 31:24
      m = d & ~{{8{mask[3]}}, {8{mask[2]}},
                {8{mask[1]}}, {8{mask[0]}}};
      case (size)
        `SZ_HALF: data_ext = {{17{sgn & m[15]}}, m[15:0]};
        `SZ_BYTE: data_ext = {{25{sgn & m[7]}}, m[7:0]};
        default:  data_ext = {sgn & m[31], m};
      endcase
    end
  endfunction

  // Read/write qualification of an address comparator
  function rw_ok;
    input [1:0] q;
    input       wr;
    begin
      case (q)
        `RW_WRITE: rw_ok = wr;
        `RW_READ:  rw_ok = ~wr;
        default:   rw_ok = 1'b1;
      endcase
    end
  endfunction

  // Combine two comparator matches per a 2-bit selector
  function sel_fn;
    input [1:0] s;
    input       x;
    input       y;
    begin
      case (s)
        `SEL_FIRST:  sel_fn = x;
        `SEL_SECOND: sel_fn = y;
        `SEL_AND:    sel_fn = x & y;
        default:     sel_fn = x | y;
      endcase
    end
  endfunction

  // One watchpoint: enabled and all cared-for event groups detected
  function wp_fn;
    input       en;
    input [1:0] ia;
    input       ia_care;
    input [1:0] la;
    input       la_care;
    input [1:0] ld;
    input       ld_care;
    input [3:0] ib;
    input [3:0] mt;
    reg         ev_i;
    reg         ev_a;
    reg         ev_d;
    begin
      ev_i  = ~ia_care | ib[ia];
      ev_a  = ~la_care | sel_fn(la, mt[0], mt[1]);
      ev_d  = ~ld_care | sel_fn(ld, mt[2], mt[3]);
      wp_fn = en & ev_i & ev_a & ev_d;
    end
  endfunction

  // Special-purpose register writes; reserved bits stay zero
  always @(posedge ref_clk) begin
    if (!rstn) begin
      lbus_comparator_config_r <= `LBUS_CMP_CFG_RESET;
      lbus_watchpoint_config_r <= `LBUS_WP_CFG_RESET;
    end else begin
      if (spr_wr && spr_addr == `SPR_LBUS_COMPARATOR_CONFIG) begin
        // Fields at 0:2 .. 9:11 map to bits 31:20
        lbus_comparator_config_r <=
          spr_wdata & `LBUS_CMP_CFG_WMASK;
      end
      if (spr_wr && spr_addr == `SPR_LBUS_WATCHPOINT_CONFIG) begin
        lbus_watchpoint_config_r[31:11] <= spr_wdata[31:11];
        lbus_watchpoint_config_r[1:0]   <= spr_wdata[1:0];
      end
      // Development-port trap enables are read-only, set from outside
      lbus_watchpoint_config_r[`DEV_TRAP0] <= dev_trap_enable[0];
      lbus_watchpoint_config_r[`DEV_TRAP1] <= dev_trap_enable[1];
    end
  end

  // Register read data; unmapped numbers read zero
  always @* begin
    rdata_nxt = spr_rdata_r;
    if (spr_rd) begin
      case (spr_addr)
        `SPR_LBUS_COMPARATOR_CONFIG: rdata_nxt = lbus_comparator_config_r;
        `SPR_LBUS_WATCHPOINT_CONFIG: rdata_nxt = lbus_watchpoint_config_r;
        default:                     rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Show-cycle selection per fetched instruction
  always @* begin
    case (fetch_showcycle_code)
      `SC_ALL:      sc_nxt = fetch_valid;
      `SC_FLOW:     sc_nxt = fetch_valid & flow_change;
      `SC_INDIRECT: sc_nxt = fetch_valid & flow_change
                             & flow_indirect;
      `SC_NONE:     sc_nxt = 1'b0;
      default:      sc_nxt = 1'b0;
    endcase
  end

  // Comparator stage: E/F watch the address, G/H the data
  always @* begin
    match_nxt[0] = lbus_valid
      & rw_ok(lbus_comparator_config_r[`RW_ADDR0], lbus_write)
      & cmp_fn(lbus_comparator_config_r[`CT_ADDR0],
               addr_ext(lbus_addr), addr_ext(ref_addr0));
    match_nxt[1] = lbus_valid
      & rw_ok(lbus_comparator_config_r[`RW_ADDR1], lbus_write)
      & cmp_fn(lbus_comparator_config_r[`CT_ADDR1],
               addr_ext(lbus_addr), addr_ext(ref_addr1));
    match_nxt[2] = lbus_valid
      & cmp_fn(lbus_comparator_config_r[`CT_DATA0],
          data_ext(lbus_data, lbus_comparator_config_r[`BM_DATA0],
                   lbus_comparator_config_r[`SZ_DATA0],
                   lbus_comparator_config_r[`SG_DATA0]),
          data_ext(ref_data0, lbus_comparator_config_r[`BM_DATA0],
                   lbus_comparator_config_r[`SZ_DATA0],
                   lbus_comparator_config_r[`SG_DATA0]));
    match_nxt[3] = lbus_valid
      & cmp_fn(lbus_comparator_config_r[`CT_DATA1],
          data_ext(lbus_data, lbus_comparator_config_r[`BM_DATA1],
                   lbus_comparator_config_r[`SZ_DATA1],
                   lbus_comparator_config_r[`SG_DATA1]),
          data_ext(ref_data1, lbus_comparator_config_r[`BM_DATA1],
                   lbus_comparator_config_r[`SZ_DATA1],
                   lbus_comparator_config_r[`SG_DATA1]));
  end

  // Watchpoint stage built from the registered comparator matches
  always @* begin
    wp_nxt[0] = wp_fn(lbus_watchpoint_config_r[`WP0_EN],
                      lbus_watchpoint_config_r[`WP0_IA],
                      lbus_watchpoint_config_r[`WP0_IA_CARE],
                      lbus_watchpoint_config_r[`WP0_LA],
                      lbus_watchpoint_config_r[`WP0_LA_CARE],
                      lbus_watchpoint_config_r[`WP0_LD],
                      lbus_watchpoint_config_r[`WP0_LD_CARE],
                      ibus_wp_event, cmp_match_r);
    wp_nxt[1] = wp_fn(lbus_watchpoint_config_r[`WP1_EN],
                      lbus_watchpoint_config_r[`WP1_IA],
                      lbus_watchpoint_config_r[`WP1_IA_CARE],
                      lbus_watchpoint_config_r[`WP1_LA],
                      lbus_watchpoint_config_r[`WP1_LA_CARE],
                      lbus_watchpoint_config_r[`WP1_LD],
                      lbus_watchpoint_config_r[`WP1_LD_CARE],
                      ibus_wp_event, cmp_match_r);
    recog = breakpoint_nonmask | recoverable_irq_status;
  end

  // Output flops
  always @(posedge ref_clk) begin
    if (!rstn) begin
      spr_rdata_r       <= 32'h00000000;
      serialize_core_r  <= 1'b1;
      fetch_showcycle_r <= 1'b0;
      cmp_match_r       <= 4'h0;
      lbus_wp_r         <= 2'h0;
      sw_break_r        <= 2'h0;
      dev_break_r       <= 2'h0;
    end else begin
      spr_rdata_r       <= rdata_nxt;
      // Code 00 keeps the core serialized even if disable is set
      serialize_core_r  <= ~serialize_disable
        | (fetch_showcycle_code == `SC_ALL);
      fetch_showcycle_r <= sc_nxt;
      cmp_match_r       <= match_nxt;
      lbus_wp_r         <= wp_nxt;
      sw_break_r[0]     <= wp_nxt[0] & recog
        & lbus_watchpoint_config_r[`SW_TRAP0];
      sw_break_r[1]     <= wp_nxt[1] & recog
        & lbus_watchpoint_config_r[`SW_TRAP1];
      dev_break_r[0]    <= wp_nxt[0] & recog
        & lbus_watchpoint_config_r[`DEV_TRAP0];
      dev_break_r[1]    <= wp_nxt[1] & recog
        & lbus_watchpoint_config_r[`DEV_TRAP1];
    end
  end

endmodule // lbus_watchpoint_compare_ctrl

// ### verification/lbus_core_model.sv
// Load/store bus of the core as seen by the watchpoint comparators
module lbus_core_model (
  input  logic        ref_clk,
  input  logic        lbus_go,
  input  logic        lbus_wr,
  input  logic [31:0] lbus_a,
  input  logic [31:0] lbus_d,
  output logic        lbus_valid,
  output logic        lbus_write,
  output logic [31:0] lbus_addr,
  output logic [31:0] lbus_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] last_a = 32'h0;
  logic [31:0] last_d = 32'h0;
  // Idle cycles show the inverse of the last access, never a stale copy
  assign lbus_valid = lbus_go;
  assign lbus_write = lbus_go ? lbus_wr : ~lbus_wr;
  assign lbus_addr  = lbus_go ? lbus_a : ~last_a;
  assign lbus_data  = lbus_go ? lbus_d : ~last_d;
  // Remember the last access
  always @(posedge ref_clk) begin
    if (lbus_go) begin
      last_a <= lbus_a;
      last_d <= lbus_d;
    end
  end
endmodule // lbus_core_model

// ### verification/lbus_watchpoint_compare_ctrl_sva.sv
// Port checks of the show-cycle and L-bus watchpoint logic
module lbus_watchpoint_compare_ctrl_sva (
  input wire       ref_clk,
  input wire       rstn,
  input wire [2:0] showcycle_serialize_field,
  input wire       fetch_valid,
  input wire       flow_change,
  input wire       flow_indirect,
  input wire       serialize_core_r,
  input wire       fetch_showcycle_r,
  input wire       lbus_valid,
  input wire [3:0] cmp_match_r,
  input wire [1:0] lbus_wp_r,
  input wire [1:0] sw_break_r,
  input wire [1:0] dev_break_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A fetch under a given show-cycle code
  sequence fetch_s(logic [1:0] c);
    showcycle_serialize_field[1:0] == c && fetch_valid;
  endsequence
  // A bus access that hit at least one comparator
  sequence access_s;
    lbus_valid ##1 cmp_match_r != 4'h0;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) !rstn |=>
    serialize_core_r && !fetch_showcycle_r && cmp_match_r == 4'h0 &&
    lbus_wp_r == 2'h0) else $error("outputs not cleared by reset");
  show_all_a: assert property (fetch_s(2'h0) |=> fetch_showcycle_r)
    else $error("fetch without show cycle");
  show_flow_a: assert property (showcycle_serialize_field[1:0] == 2'h1
    |=> fetch_showcycle_r == $past(fetch_valid && flow_change))
    else $error("flow change show cycle wrong");
  show_indirect_a: assert property (showcycle_serialize_field[1:0] == 2'h2
    |=> fetch_showcycle_r == $past(fetch_valid && flow_change && flow_indirect))
    else $error("indirect show cycle wrong");
  show_none_a: assert property (fetch_s(2'h3) |=> !fetch_showcycle_r)
    else $error("show cycle under code 11");
  serialize_mode_a: assert property (1'b1 |=> serialize_core_r ==
    !$past(showcycle_serialize_field[2] && showcycle_serialize_field[1:0] != 0))
    else $error("serialization level wrong");
  idle_nomatch_a: assert property (!lbus_valid |=> cmp_match_r == 4'h0)
    else $error("match without bus access");
  wp_cause_a: assert property (lbus_wp_r != 2'h0 |-> $past(lbus_valid, 2))
    else $error("watchpoint without access");
  break_gate_a: assert property ((sw_break_r | dev_break_r) != 2'h0 |->
    ((sw_break_r | dev_break_r) & ~lbus_wp_r) == 2'h0)
    else $error("break without watchpoint");
  wp_seen_c: cover property (access_s ##1 lbus_wp_r != 2'h0);
endmodule // lbus_watchpoint_compare_ctrl_sva

// ### verification/tb_top.sv
// Self-checking bench of the show-cycle and L-bus watchpoint logic
`include "lbus_watchpoint_defines.vh"
`define CHK(g, e) begin logic [31:0] t; t = e; n_compared++; \
  if ((g) !== t) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, g, t); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, rstn = 0, spr_wr = 0, spr_rd = 0;
  logic        fetch_valid = 0, flow_change = 0, flow_indirect = 0;
  logic        lbus_go = 0, lbus_wr = 0, recoverable_irq_status = 0;
  logic [1:0]  dev_trap_enable = 2'h0;
  logic [2:0]  showcycle_serialize_field = 3'h0;
  logic [3:0]  ibus_wp_event = 4'h0;
  logic [9:0]  spr_addr = 10'h0;
  logic [31:0] spr_wdata = 0, lbus_a = 0, lbus_d = 0, seed = 32'hD87B;
  logic [31:0] ref_addr0 = 0, ref_addr1 = 0, ref_data0 = 0, ref_data1 = 0;
  wire  [31:0] spr_rdata_r, lbus_addr, lbus_data;
  wire         serialize_core_r, fetch_showcycle_r, lbus_valid, lbus_write;
  wire  [3:0]  cmp_match_r;
  wire  [1:0]  lbus_wp_r, sw_break_r, dev_break_r;
  logic [31:0] r_q[$];
  logic [3:0]  m_q[$];
  logic [5:0]  w_q[$];
  logic        rd_d = 0, lv_d = 0, lv_d2 = 0;
  int          num_errors = 0, n_compared = 0, cyc = 0;
  lbus_watchpoint_compare_ctrl lbus_watchpoint_compare_ctrl_inst (.*);
  lbus_core_model lbus_core_model_inst (.*);
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected comparator hit from type, operands and signedness
  function automatic logic cmpf(logic [2:0] c, logic [31:0] x, y, logic s);
    logic lt, gt;
    lt = s ? $signed(x) < $signed(y) : x < y;
    gt = s ? $signed(x) > $signed(y) : x > y;
    return c[2] & (c[1:0] == 0 ? x == y : c[1:0] == 1 ? lt :
                   c[1:0] == 2 ? gt : x != y);
  endfunction
  // One falling edge with fresh random fetch traffic
  task automatic step();
    logic [31:0] r;
    @(negedge ref_clk);
    r = rnd();
    {fetch_valid, flow_change, flow_indirect} = r[2:0];
    showcycle_serialize_field = r[5:3] == 3'h4 ? 3'h0 : r[5:3];
  endtask
  task automatic wr(logic [9:0] a, logic [31:0] d);
    step();
    {spr_addr, spr_wdata, spr_wr} = {a, d, 1'b1};
    step();
    spr_wr = 0;
  endtask
  task automatic rd(logic [9:0] a, logic [31:0] e);
    step();
    r_q.push_back(e);
    {spr_addr, spr_rd} = {a, 1'b1};
    step();
    spr_rd = 0;
  endtask
  task automatic acc(logic w, logic [31:0] a, d, logic [3:0] m,
                     logic [5:0] v);
    step();
    m_q.push_back(m);
    w_q.push_back(v);
    {lbus_wr, lbus_a, lbus_d, lbus_go} = {w, a, d, 1'b1};
    step();
    lbus_go = 0;
    step();
  endtask
  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Strobe pipeline and hang guard
  always @(posedge ref_clk) begin
    {rd_d, lv_d, lv_d2} <= {spr_rd, lbus_valid, lv_d};
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  // Each result is compared with the oldest note when it appears
  always @(negedge ref_clk) begin
    if (rd_d) `CHK(spr_rdata_r, r_q.pop_front())
    if (lv_d) `CHK(cmp_match_r, m_q.pop_front())
    if (lv_d2) `CHK({dev_break_r, sw_break_r, lbus_wp_r}, w_q.pop_front())
  end
  initial begin
    logic [31:0] a, d;
    repeat (20) @(negedge ref_clk);
    rstn = 1;
    rd(`SPR_LBUS_COMPARATOR_CONFIG, 32'h0);
    rd(`SPR_LBUS_WATCHPOINT_CONFIG, 32'h0);
    rd(10'h09E, 32'h0);
    wr(`SPR_LBUS_COMPARATOR_CONFIG, 32'hFFFFFFFF);
    rd(`SPR_LBUS_COMPARATOR_CONFIG, `LBUS_CMP_CFG_WMASK);
    // Every compare type on all comparators, G unsigned and H signed
    for (int t = 0; t < 8; t++) begin
      wr(`SPR_LBUS_COMPARATOR_CONFIG, {t[2:0], t[2:0], t[2:0], t[2:0],
         4'h0, `SZ_WORD, `SZ_WORD, 2'h1, 10'h0});
      for (int k = 0; k < 3; k++) begin
        a = rnd();
        d = rnd();
        ref_addr0 = k == 0 ? a : rnd();
        ref_addr1 = rnd();
        ref_data0 = k == 0 ? d : rnd();
        ref_data1 = k == 1 ? d : rnd();
        acc(k[0], a, d, {cmpf(t[2:0], d, ref_data1, 1),
            cmpf(t[2:0], d, ref_data0, 0), cmpf(t[2:0], a, ref_addr1, 0),
            cmpf(t[2:0], a, ref_addr0, 0)}, 4'h0);
      end
    end
    // Write-only address hit, masked last lane, byte-size data
    wr(`SPR_LBUS_COMPARATOR_CONFIG, {`CT_EQ, 3'h0, `CT_EQ, `CT_EQ,
       `RW_WRITE, 2'h0, `SZ_WORD, `SZ_BYTE, 2'h0, 4'h1, 6'h0});
    ref_addr0 = a;
    ref_data1 = d ^ 32'hFFFFFF00;
    ref_data0 = d ^ 32'h000000FF;
    acc(0, a, d, 4'hC, 4'h0);
    acc(1, a, d, 4'hD, 4'h0);
    ref_data0 = d ^ 32'h00000100;
    acc(1, a, d, 4'h9, 4'h0);
    // Address event selector with E hitting and F missing
    wr(`SPR_LBUS_COMPARATOR_CONFIG, {`CT_EQ, `CT_EQ, 26'h0});
    ref_addr1 = ~a;
    for (int s = 0; s < 4; s++) begin
      d = {1'b1, 3'h0, s[1:0], 1'b1, 13'h0, s[0], 9'h0, 2'h2};
      wr(`SPR_LBUS_WATCHPOINT_CONFIG, d);
      rd(`SPR_LBUS_WATCHPOINT_CONFIG, d);
      acc(0, a, 0, 4'h1, {1'b0, s == 3, 1'b0, s == 0 || s == 3});
    end
    // Instruction-address event tied to the third I-bus watchpoint
    wr(`SPR_LBUS_WATCHPOINT_CONFIG, 32'hD2000000);
    // Development trap of the first watchpoint, recognised via status
    dev_trap_enable = 2'h1;
    recoverable_irq_status = 1'b1;
    ibus_wp_event = 4'hB;
    acc(1, a, 0, 4'h1, 4'h0);
    ibus_wp_event = 4'h4;
    acc(1, a, 0, 4'h1, 6'h11);
    repeat (4) step();
    complete_run();
  end
endmodule // tb_top
bind lbus_watchpoint_compare_ctrl lbus_watchpoint_compare_ctrl_sva
  lbus_watchpoint_compare_ctrl_sva_inst (.*);
